//--- hdl/pas_cfg.sv
// Phase alarm timer and sync output shaping registers
`timescale 1ns/1ps
`default_nettype none
module pas_cfg #(
    parameter int TICKS_PER_UNIT = pas_pkg::PAS_UNIT_S * pas_pkg::PAS_CLK_HZ
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic loop_unsettled_i,
    input wire logic alarm_clear_i,
    input wire logic auto_timeout_en_i,
    input wire logic auto_timeout_tick_i,
    output logic phase_alarm_o,
    output logic input_blocked_o,
    input wire logic primary_fs_i,
    input wire logic primary_mf_i,
    input wire logic secondary_fs_i,
    input wire logic secondary_mf_i,
    input wire logic primary_clk_en_i,
    input wire logic secondary_clk_en_i,
    input wire logic second_clock_enabled_i,
    output logic sync_source_select_o,
    output logic frame_sync_out_o,
    output logic multiframe_sync_out_o
);
    import pas_pkg::*;

    typedef struct packed {
        logic [7:0] delay;
        logic [7:0] shape;
        logic [31:0] tick;
        logic [5:0] units;
        logic alarm;
        logic fs_prev;
        logic mf_prev;
        logic fs_pulse;
        logic mf_pulse;
        logic fs_out;
        logic mf_out;
    } pas_state_t;

    pas_state_t s_q, s_d;
    logic fs_src, mf_src, clk_en;

    // Shaped output for one sync line
    function automatic logic pas_shape(input logic lvl, input logic pul,
        input logic pmode, input logic inv, input logic o2en);
        logic v;
        v = (pmode && o2en) ? pul : lvl;
        return v ^ inv;
    endfunction

    always_comb begin
        s_d = s_q;
        fs_src = s_q.shape[PAS_BIT_SRC] ? secondary_fs_i : primary_fs_i;
        mf_src = s_q.shape[PAS_BIT_SRC] ? secondary_mf_i : primary_mf_i;
        clk_en = s_q.shape[PAS_BIT_SRC] ? secondary_clk_en_i
                                        : primary_clk_en_i;
        if (wr_en_i && addr_i == PAS_ADDR_DELAY) begin
            s_d.delay = wdata_i & PAS_DELAY_MASK;
        end
        if (wr_en_i && addr_i == PAS_ADDR_SHAPE) begin
            s_d.shape = wdata_i & PAS_SHAPE_MASK;
        end
        // Timer runs only while the loop is unsettled and no alarm
        if (!loop_unsettled_i || s_q.alarm) begin
            s_d.tick = '0;
            s_d.units = '0;
        end else if (s_q.tick == 32'(TICKS_PER_UNIT - 1)) begin
            s_d.tick = '0;
            s_d.units = s_q.units + 6'h1;
            // Equality lets a zero field wrap to 64 units
            if (s_q.units + 6'h1 == s_q.delay[5:0]) begin
                s_d.alarm = 1'b1;
            end
        end else begin
            s_d.tick = s_q.tick + 32'h0000_0001;
        end
        // Raise wins over clear in the same cycle
        if ((alarm_clear_i || (auto_timeout_en_i && auto_timeout_tick_i))
            && s_d.alarm == s_q.alarm) begin
            s_d.alarm = 1'b0;
        end
        // Pulse is one second-clock period wide, on each sync rising edge
        if (clk_en) begin
            s_d.fs_prev = fs_src;
            s_d.mf_prev = mf_src;
            s_d.fs_pulse = fs_src && !s_q.fs_prev;
            s_d.mf_pulse = mf_src && !s_q.mf_prev;
        end
        s_d.fs_out = pas_shape(fs_src, s_q.fs_pulse,
            s_q.shape[PAS_BIT_FS_SHP], s_q.shape[PAS_BIT_FS_POL],
            second_clock_enabled_i);
        s_d.mf_out = pas_shape(mf_src, s_q.mf_pulse,
            s_q.shape[PAS_BIT_MF_SHP], s_q.shape[PAS_BIT_MF_POL],
            second_clock_enabled_i);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            s_q <= '{delay: PAS_DELAY_RST, shape: PAS_SHAPE_RST,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        unique case (addr_i)
            PAS_ADDR_DELAY: rdata_o = s_q.delay;
            PAS_ADDR_SHAPE: rdata_o = s_q.shape;
            default: rdata_o = 8'h00;
        endcase
    end

    assign phase_alarm_o = s_q.alarm;
    assign input_blocked_o = s_q.alarm;
    assign sync_source_select_o = s_q.shape[PAS_BIT_SRC];
    assign frame_sync_out_o = s_q.fs_out;
    assign multiframe_sync_out_o = s_q.mf_out;

    a_unused_zero: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (s_q.delay[7:6] == 2'b00) && (s_q.shape[6:4] == 3'b000))
        else $error("unused bits set");
    a_alarm_holds: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_q.alarm && !alarm_clear_i && !auto_timeout_tick_i |=> s_q.alarm)
        else $error("alarm dropped");
    a_alarm_cause: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(s_q.alarm) |-> $past(loop_unsettled_i))
        else $error("alarm without unsettled loop");
    a_src_select: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_en_i && addr_i == PAS_ADDR_SHAPE |=>
        sync_source_select_o == $past(wdata_i[PAS_BIT_SRC]))
        else $error("source select mismatch");
    a_fs_square: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !s_q.shape[PAS_BIT_FS_SHP] && $stable(s_q.shape) |=>
        frame_sync_out_o == ($past(fs_src)
            ^ $past(s_q.shape[PAS_BIT_FS_POL])))
        else $error("frame sync level wrong");
    a_fs_needs_o2: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !second_clock_enabled_i && $stable(s_q.shape) |=>
        frame_sync_out_o == ($past(fs_src)
            ^ $past(s_q.shape[PAS_BIT_FS_POL])))
        else $error("pulse mode without second clock");
    a_mf_square: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !s_q.shape[PAS_BIT_MF_SHP] && $stable(s_q.shape) |=>
        multiframe_sync_out_o == ($past(mf_src)
            ^ $past(s_q.shape[PAS_BIT_MF_POL])))
        else $error("multiframe level wrong");
    a_pulse_edge: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        clk_en && !(fs_src && !s_q.fs_prev) |=> !s_q.fs_pulse)
        else $error("pulse without edge");
    a_fs_pulsed: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_q.shape[PAS_BIT_FS_SHP] && second_clock_enabled_i |=>
        frame_sync_out_o == ($past(s_q.fs_pulse)
            ^ $past(s_q.shape[PAS_BIT_FS_POL])))
        else $error("frame sync pulse wrong");
    a_mf_pulsed: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_q.shape[PAS_BIT_MF_SHP] && second_clock_enabled_i |=>
        multiframe_sync_out_o == ($past(s_q.mf_pulse)
            ^ $past(s_q.shape[PAS_BIT_MF_POL])))
        else $error("multiframe pulse wrong");
    a_mf_needs_o2: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !second_clock_enabled_i |=>
        multiframe_sync_out_o == ($past(mf_src)
            ^ $past(s_q.shape[PAS_BIT_MF_POL])))
        else $error("multiframe pulse without second clock");
    a_src_route: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_q.shape[PAS_BIT_SRC] && !second_clock_enabled_i |=>
        frame_sync_out_o == ($past(secondary_fs_i)
            ^ $past(s_q.shape[PAS_BIT_FS_POL])))
        else $error("secondary loop not routed");
    a_prim_route: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !s_q.shape[PAS_BIT_SRC] && !second_clock_enabled_i |=>
        frame_sync_out_o == ($past(primary_fs_i)
            ^ $past(s_q.shape[PAS_BIT_FS_POL])))
        else $error("primary loop not routed");
    a_pulse_hold: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !clk_en |=> $stable(s_q.fs_pulse) && $stable(s_q.mf_pulse))
        else $error("pulse changed between clock enables");
    a_pulse_set: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        clk_en && fs_src && !s_q.fs_prev |=> s_q.fs_pulse)
        else $error("frame pulse missed");
    a_mf_pulse_set: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        clk_en && mf_src && !s_q.mf_prev |=> s_q.mf_pulse)
        else $error("multiframe pulse missed");
    a_alarm_clear: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_q.alarm && (alarm_clear_i
            || (auto_timeout_en_i && auto_timeout_tick_i)) |=> !s_q.alarm)
        else $error("alarm not cleared");
    a_raise_wins: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !s_q.alarm && loop_unsettled_i
            && s_q.tick == 32'(TICKS_PER_UNIT - 1)
            && s_q.units + 6'h1 == s_q.delay[5:0] |=> s_q.alarm)
        else $error("alarm not raised at timeout");
    a_idle_timer: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !loop_unsettled_i |=> s_q.tick == 32'h0000_0000
            && s_q.units == 6'h00)
        else $error("timer ran while loop settled");
    a_delay_write: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_en_i && addr_i == PAS_ADDR_DELAY |=>
        s_q.delay == ($past(wdata_i) & PAS_DELAY_MASK))
        else $error("delay write wrong");
    a_other_addr: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_en_i && addr_i != PAS_ADDR_DELAY && addr_i != PAS_ADDR_SHAPE |=>
        $stable(s_q.delay) && $stable(s_q.shape))
        else $error("stray write landed");
    a_unmapped_read: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        addr_i != PAS_ADDR_DELAY && addr_i != PAS_ADDR_SHAPE |->
        rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule // pas_cfg
`default_nettype wire

//--- hdl/pas_pkg.sv
// Constants for the phase alarm and sync output configuration block
package pas_pkg;
    localparam logic [7:0] PAS_ADDR_DELAY = 8'h79;
    localparam logic [7:0] PAS_ADDR_SHAPE = 8'h7A;
    localparam logic [7:0] PAS_DELAY_RST = 8'h32;
    localparam logic [7:0] PAS_SHAPE_RST = 8'h00;
    localparam logic [7:0] PAS_DELAY_MASK = 8'h3F;
    localparam logic [7:0] PAS_SHAPE_MASK = 8'h8F;
    localparam int PAS_BIT_SRC = 7;
    localparam int PAS_BIT_FS_POL = 3;
    localparam int PAS_BIT_FS_SHP = 2;
    localparam int PAS_BIT_MF_POL = 1;
    localparam int PAS_BIT_MF_SHP = 0;
    localparam int PAS_UNIT_S = 2;
    localparam int PAS_CLK_HZ = 100_000_000;
endpackage

//--- sim/pas_sync_src.sv
// Loop-side sync squares and second-clock enable
`timescale 1ns/1ps
`default_nettype none
module pas_sync_src (
    input wire logic ref_clk_i,
    output logic [5:0] phase_o,
    output logic fs_o,
    output logic mf_o,
    output logic clk_en_o
);
    initial phase_o = 6'h00;
    always @(posedge ref_clk_i) begin
        phase_o <= phase_o + 6'h01;
    end
    assign fs_o = phase_o[3];
    assign mf_o = phase_o[5];
    // Second clock period of four cycles
    assign clk_en_o = (phase_o[1:0] == 2'h3);
endmodule // pas_sync_src
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the sync shaping and alarm registers
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pas_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, uns = 1'b0, clr = 1'b0;
    logic o2 = 1'b0, ate = 1'b0, atk = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd;
    logic [5:0] ph;
    logic fs, mf, ce, src, fso, mfo, alm, blk;
    logic [31:0] seed = 32'hcb62_9445;
    int n_fail = 0, samples_checked = 0;
    pas_sync_src i_src (.ref_clk_i(clk), .phase_o(ph), .fs_o(fs), .mf_o(mf),
        .clk_en_o(ce));
    pas_cfg #(.TICKS_PER_UNIT(4)) i_dut (.ref_clk_i(clk), .reset_n_i(rst_n),
        .wr_en_i(we), .addr_i(addr), .wdata_i(wd), .rdata_o(rd),
        .loop_unsettled_i(uns), .alarm_clear_i(clr), .auto_timeout_en_i(ate),
        .auto_timeout_tick_i(atk), .phase_alarm_o(alm), .input_blocked_o(blk),
        .primary_fs_i(fs), .primary_mf_i(mf), .secondary_fs_i(~fs),
        .secondary_mf_i(~mf), .primary_clk_en_i(ce), .secondary_clk_en_i(ce),
        .second_clock_enabled_i(o2), .sync_source_select_o(src),
        .frame_sync_out_o(fso), .multiframe_sync_out_o(mfo));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wd = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, exp);
        @(negedge clk);
        addr = a;
        #1 chk("rdata", rd, exp);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #100_000;
        n_fail++;
        close_out();
    end
    initial begin
        logic [7:0] v;
        int fh, mh;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rdc(PAS_ADDR_DELAY, PAS_DELAY_RST);
        rdc(PAS_ADDR_SHAPE, PAS_SHAPE_RST);
        // Pulse bit set with second clock off must stay square
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 8'hFF : 8'(rnd());
            wr(8'h55, ~v);
            wr(PAS_ADDR_DELAY, v);
            rdc(PAS_ADDR_DELAY, v & PAS_DELAY_MASK);
            wr(PAS_ADDR_SHAPE, v);
            rdc(PAS_ADDR_SHAPE, v & PAS_SHAPE_MASK);
            rdc(8'h55, 8'h00);
            chk("source", {7'h00, src}, {7'h00, v[7]});
            while (ph[2:0] != 3'h6) @(negedge clk);
            chk("frame", {7'h00, fso}, {7'h00, fs ^ v[7] ^ v[3]});
            chk("mframe", {7'h00, mfo}, {7'h00, mf ^ v[7] ^ v[1]});
        end
        o2 = 1'b1;
        wr(PAS_ADDR_SHAPE, 8'h05);
        repeat (70) @(negedge clk);
        fh = 0;
        mh = 0;
        repeat (64) begin
            @(negedge clk);
            fh += int'(fso);
            mh += int'(mfo);
        end
        chk("frame_high", 8'(fh), 8'h10);
        chk("mframe_high", 8'(mh), 8'h04);
        wr(PAS_ADDR_DELAY, 8'hC2);
        uns = 1'b1;
        repeat (5) @(negedge clk);
        chk("alarm_early", {7'h00, alm}, 8'h00);
        repeat (8) @(negedge clk);
        chk("alarm", {7'h00, alm}, 8'h01);
        chk("blocked", {7'h00, blk}, 8'h01);
        uns = 1'b0;
        repeat (6) @(negedge clk);
        chk("alarm_held", {7'h00, alm}, 8'h01);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        chk("alarm_clr", {7'h00, alm}, 8'h00);
        // Zero field means 64 units of four cycles
        wr(PAS_ADDR_DELAY, 8'h00);
        uns = 1'b1;
        repeat (250) @(negedge clk);
        chk("alarm_wrap_early", {7'h00, alm}, 8'h00);
        repeat (10) @(negedge clk);
        chk("alarm_wrap", {7'h00, alm}, 8'h01);
        uns = 1'b0;
        atk = 1'b1;
        @(negedge clk);
        atk = 1'b0;
        @(negedge clk);
        chk("alarm_tick_off", {7'h00, alm}, 8'h01);
        ate = 1'b1;
        atk = 1'b1;
        @(negedge clk);
        atk = 1'b0;
        @(negedge clk);
        chk("alarm_expired", {7'h00, alm}, 8'h00);
        chk("unblocked", {7'h00, blk}, 8'h00);
        close_out();
    end
endmodule // tb
`default_nettype wire
